// file: shared/pio_pkg.sv
// package of constants and carrier types for the parallel io ports
// Function
// - port zero byte-wide open-drain with latch per pin
// - port zero carries address low and data externally
// - latch captures internal bus on write strobe
// - read latch or sampled pin onto internal bus
// - external access sets port zero latch all ones
// - external access: port zero push-pull from bus
// - port zero latch one floats the pin
// - port zero latch zero drives low
// - port one splits into two io, six inputs
// - port one io pins pulled high or drive low
// - timer two functions need latch one
// - pwm output overrides latch on pin
// - pin zero timer count/pwm_channel_zero_out, pin one trigger/pwm_channel_one_out
// - rising latch gives strong pull-up two periods
// - pin pulled low drops keeper, very weak stays
// - upper port one latches reset one, analog select
// - upper port one pins never driven
// - port two outputs high and middle address bytes
// - external mode port two push-pull, latch unchanged
// - port two latch one pulled high, zero drives low
// - read-modify-write reads the latch
package pio_pkg;
	localparam int          PIO_W       = 8;
	localparam logic [7:0]  PIO_RST     = 8'h00_ff;
	localparam logic [7:0]  PIO_ONES    = 8'h00_ff;
	localparam int          PIO_IO_LO   = 0;
	localparam int          PIO_IO_HI   = 1;
	localparam int          PIO_AIN_LO  = 2;
	// strong pull-up time in oscillator periods, one period is one clk
	localparam int          PIO_STRONG_PER = 2;
	localparam logic [1:0]  PIO_STRONG_CNT = 2'(PIO_STRONG_PER);
	// port selector on the core side
	typedef enum logic [1:0] {
		PIO_SEL_P0,
		PIO_SEL_P1,
		PIO_SEL_P2,
		PIO_SEL_NONE
	} pio_sel_t;
	// drive of one pin with internal pull-ups
	typedef struct packed {
		logic strong_up;
		logic keeper_up;
		logic weak_up;
		logic drive_low;
	} pio_pull_t;
	// core access bundle
	typedef struct packed {
		pio_sel_t   sel;
		logic       wr;
		logic       rd_latch;
		logic       rd_pin;
		logic [7:0] wdata;
	} pio_core_t;
endpackage : pio_pkg

// file: hw/pio_pullup.sv
// one active pull-up cell: strong burst, keeper and very weak source
`timescale 1ns/10ps
module pio_pullup
	import pio_pkg::*;
(
	// clock and reset
	input  wire logic clk_i,
	input  wire logic rstn_i,
	// control
	input  wire logic latch_i,
	input  wire logic force_i,
	input  wire logic pin_i,
	// drive
	output pio_pull_t pull_o
);
	logic       latch_q;
	logic [1:0] cnt_q;
	logic       keep_q;

	// previous latch for rising edge detect
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			latch_q <= 1'b1;
		end else begin
			latch_q <= latch_i;
		end
	end

	// strong burst counter, restarts on every rising latch
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= 2'd0;
		end else if (latch_i && !latch_q) begin
			cnt_q <= PIO_STRONG_CNT;
		end else if (cnt_q != 2'd0) begin
			cnt_q <= cnt_q - 2'd1;
		end
	end

	// keeper latches high once the pin is up, drops on an external low
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			keep_q <= 1'b1;
		end else if (!latch_i || force_i) begin
			keep_q <= 1'b0;
		end else if (!pin_i && cnt_q == 2'd0) begin
			keep_q <= 1'b0;
		end else if (pin_i) begin
			keep_q <= 1'b1;
		end
	end

	// pull-ups only while the latch asks for a high and nothing overrides
	always_comb begin
		pull_o.strong_up = latch_i && !force_i && (cnt_q != 2'd0);
		pull_o.keeper_up = latch_i && !force_i && keep_q && cnt_q == 2'd0;
		pull_o.weak_up   = latch_i && !force_i;
		pull_o.drive_low = !latch_i && !force_i;
	end

	property p_strong_len;
		@(posedge clk_i) disable iff (!rstn_i)
		(latch_i && !latch_q && !force_i) |=> pull_o.strong_up[*2]
			##1 !pull_o.strong_up;
	endproperty
	a_strong_len: assert property (p_strong_len)
		else $error("strong pull-up not two periods");

	property p_strong_gap;
		@(posedge clk_i) disable iff (!rstn_i)
		pull_o.strong_up |-> !pull_o.keeper_up;
	endproperty
	a_strong_gap: assert property (p_strong_gap)
		else $error("strong and keeper at once");

	// an external low after the burst must take the keeper away
	property p_keep_drop;
		@(posedge clk_i) disable iff (!rstn_i)
		(latch_i && !force_i && !pin_i && cnt_q == 2'd0)
			|=> !pull_o.keeper_up;
	endproperty
	a_keep_drop: assert property (p_keep_drop)
		else $error("keeper stays on against a low pin");
endmodule : pio_pullup

// file: hw/pio_ports.sv
// three byte-wide parallel ports with latches, pin muxing and pull-ups
`timescale 1ns/10ps
module pio_ports
	import pio_pkg::*;
(
	// clock and reset
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	// core access
	input  pio_core_t       core_i,
	input  wire logic       rmw_i,
	output logic [7:0]      rdata_o,
	// external memory bus
	input  wire logic       ext_acc_i,
	input  wire logic [7:0] ext_p0_i,
	input  wire logic [7:0] ext_p2_i,
	// timer two, pwm and analog select
	input  wire logic       pwm_channel_zero_out_en_i,
	input  wire logic       pwm_channel_zero_out_i,
	input  wire logic       pwm_channel_one_out_en_i,
	input  wire logic       pwm_channel_one_out_i,
	output logic            timer_two_count_input_o,
	output logic            timer_two_capture_trigger_o,
	output logic [5:0]      ain_sel_o,
	// port zero pins
	input  wire logic [7:0] p0_pin_i,
	output logic [7:0]      p0_pin_o,
	output logic [7:0]      p0_pin_oe_o,
	// port one pins
	input  wire logic [7:0] p1_pin_i,
	output logic [1:0]      p1_pin_o,
	output logic [1:0]      p1_pin_oe_o,
	output pio_pull_t [1:0] p1_pull_o,
	// port two pins
	input  wire logic [7:0] p2_pin_i,
	output logic [7:0]      p2_pin_o,
	output logic [7:0]      p2_pin_oe_o,
	output pio_pull_t [7:0] p2_pull_o
);
	logic [7:0]  port_zero_latch_q;
	logic [7:0]  port_one_latch_q;
	logic [7:0]  port_two_latch_q;
	logic [23:0] s1_q;
	logic [23:0] s2_q;
	logic [23:0] s3_q;
	logic [23:0] pin_q;
	logic [7:0]  rdata_d;
	logic [1:0]  pwm_en;
	logic [1:0]  pwm_val;

	// write strobe for one port
	function automatic logic wr_hit(pio_core_t c, pio_sel_t s);
		return c.wr && (c.sel == s);
	endfunction : wr_hit

	// port zero latch; external access forces ones and wins over writes
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_zero_latch_q <= PIO_RST;
		end else if (ext_acc_i) begin
			port_zero_latch_q <= PIO_ONES;
		end else if (wr_hit(core_i, PIO_SEL_P0)) begin
			port_zero_latch_q <= core_i.wdata;
		end
	end

	// port one latch, upper bits select analog when one
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_one_latch_q <= PIO_RST;
		end else if (wr_hit(core_i, PIO_SEL_P1)) begin
			port_one_latch_q <= core_i.wdata;
		end
	end

	// port two latch is untouched by external accesses
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			port_two_latch_q <= PIO_RST;
		end else if (wr_hit(core_i, PIO_SEL_P2)) begin
			port_two_latch_q <= core_i.wdata;
		end
	end

	// three-stage pin sampling; a level counts once stages two and three agree
	// reset to the pulled-up idle level so keepers see no false low
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			s1_q <= '1;
			s2_q <= '1;
			s3_q <= '1;
		end else begin
			s1_q <= {p2_pin_i, p1_pin_i, p0_pin_i};
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// filtered pin level, holds on disagreement
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pin_q <= '1;
		end else begin
			pin_q <= (s2_q & s3_q) | (pin_q & (s2_q | s3_q));
		end
	end

	// read mux; read-modify-write always takes the latch
	always_comb begin
		logic [7:0] lat;
		logic [7:0] pin;
		lat = 8'h00_00;
		pin = 8'h00_00;
		unique case (core_i.sel)
			PIO_SEL_P0: begin
				lat = port_zero_latch_q;
				pin = pin_q[7:0];
			end
			PIO_SEL_P1: begin
				lat = port_one_latch_q;
				pin = pin_q[15:8];
			end
			PIO_SEL_P2: begin
				lat = port_two_latch_q;
				pin = pin_q[23:16];
			end
			PIO_SEL_NONE: begin
				lat = 8'h00_00;
				pin = 8'h00_00;
			end
		endcase
		if (core_i.rd_latch || rmw_i) begin
			rdata_d = lat;
		end else if (core_i.rd_pin) begin
			rdata_d = pin;
		end else begin
			rdata_d = 8'h00_00;
		end
	end

	// registered read data
	always_ff @(posedge clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rdata_o <= 8'h00_00;
		end else begin
			rdata_o <= rdata_d;
		end
	end

	// port zero: open drain in gpio mode, push-pull address/data externally
	always_comb begin
		if (ext_acc_i) begin
			p0_pin_o    = ext_p0_i;
			p0_pin_oe_o = PIO_ONES;
		end else begin
			p0_pin_o    = 8'h00_00;
			p0_pin_oe_o = ~port_zero_latch_q;
		end
	end

	// port two: address push-pull externally, else quasi-bidirectional
	always_comb begin
		if (ext_acc_i) begin
			p2_pin_o    = ext_p2_i;
			p2_pin_oe_o = PIO_ONES;
		end else begin
			p2_pin_o    = 8'h00_00;
			p2_pin_oe_o = ~port_two_latch_q;
		end
	end

	// pwm overrides the latch; a zero latch still pins timer inputs low
	assign pwm_en  = {pwm_channel_one_out_en_i, pwm_channel_zero_out_en_i};
	assign pwm_val = {pwm_channel_one_out_i, pwm_channel_zero_out_i};

	// port one low pins: pwm drives push-pull, else latch low or pull-up
	always_comb begin
		for (int i = PIO_IO_LO; i <= PIO_IO_HI; i++) begin
			if (pwm_en[i]) begin
				p1_pin_o[i]    = pwm_val[i];
				p1_pin_oe_o[i] = 1'b1;
			end else begin
				p1_pin_o[i]    = 1'b0;
				p1_pin_oe_o[i] = !port_one_latch_q[i];
			end
		end
	end

	// timer two sees zero unless the latch is one
	always_comb begin
		timer_two_count_input_o     = port_one_latch_q[0] & pin_q[8];
		timer_two_capture_trigger_o = port_one_latch_q[1] & pin_q[9];
	end

	// upper port one pins: input only, latch is just the analog select
	assign ain_sel_o = port_one_latch_q[7:PIO_AIN_LO];

	// pull-up cells for port one io pins and all port two pins
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_p1_pull
			pio_pullup u_pull (
				.clk_i   (clk_i),
				.rstn_i  (rstn_i),
				.latch_i (port_one_latch_q[g]),
				.force_i (pwm_en[g]),
				.pin_i   (pin_q[8+g]),
				.pull_o  (p1_pull_o[g])
			);
		end
		for (g = 0; g < PIO_W; g++) begin : g_p2_pull
			pio_pullup u_pull (
				.clk_i   (clk_i),
				.rstn_i  (rstn_i),
				.latch_i (port_two_latch_q[g]),
				.force_i (ext_acc_i),
				.pin_i   (pin_q[16+g]),
				.pull_o  (p2_pull_o[g])
			);
		end
	endgenerate

	property p_ext_ones;
		@(posedge clk_i) disable iff (!rstn_i)
		ext_acc_i |=> port_zero_latch_q == PIO_ONES;
	endproperty
	a_ext_ones: assert property (p_ext_ones)
		else $error("port zero latch not ones after access");

	property p_p0_push;
		@(posedge clk_i) disable iff (!rstn_i)
		ext_acc_i |-> p0_pin_oe_o == PIO_ONES && p0_pin_o == ext_p0_i;
	endproperty
	a_p0_push: assert property (p_p0_push)
		else $error("port zero not driving bus");

	property p_p0_od;
		@(posedge clk_i) disable iff (!rstn_i)
		!ext_acc_i |-> p0_pin_oe_o == ~port_zero_latch_q && p0_pin_o == 8'h00_00;
	endproperty
	a_p0_od: assert property (p_p0_od)
		else $error("port zero open drain wrong");

	property p_p2_keep;
		@(posedge clk_i) disable iff (!rstn_i)
		(ext_acc_i && !core_i.wr) |=> $stable(port_two_latch_q);
	endproperty
	a_p2_keep: assert property (p_p2_keep)
		else $error("port two latch changed by access");

	property p_p2_addr;
		@(posedge clk_i) disable iff (!rstn_i)
		ext_acc_i |-> p2_pin_o == ext_p2_i && p2_pin_oe_o == PIO_ONES;
	endproperty
	a_p2_addr: assert property (p_p2_addr)
		else $error("port two not driving address");

	property p_write;
		@(posedge clk_i) disable iff (!rstn_i)
		wr_hit(core_i, PIO_SEL_P1) |=> port_one_latch_q == $past(core_i.wdata);
	endproperty
	a_write: assert property (p_write)
		else $error("port one latch missed write");

	property p_rmw;
		@(posedge clk_i) disable iff (!rstn_i)
		(rmw_i && core_i.sel == PIO_SEL_P2) |=> rdata_o == $past(port_two_latch_q);
	endproperty
	a_rmw: assert property (p_rmw)
		else $error("rmw read not from latch");

	property p_pwm;
		@(posedge clk_i) disable iff (!rstn_i)
		pwm_channel_zero_out_en_i |-> p1_pin_oe_o[0] && p1_pin_o[0] == pwm_channel_zero_out_i;
	endproperty
	a_pwm: assert property (p_pwm)
		else $error("pwm not on pin zero");

	property p_t2;
		@(posedge clk_i) disable iff (!rstn_i)
		!port_one_latch_q[0] |-> !timer_two_count_input_o;
	endproperty
	a_t2: assert property (p_t2)
		else $error("timer input not stuck low");

	c_ext: cover property (@(posedge clk_i) disable iff (!rstn_i)
		ext_acc_i ##1 !ext_acc_i);
	c_rdpin: cover property (@(posedge clk_i) disable iff (!rstn_i)
		core_i.rd_pin && !rmw_i && core_i.sel == PIO_SEL_P0);
	c_pwm: cover property (@(posedge clk_i) disable iff (!rstn_i)
		pwm_channel_one_out_en_i && !port_one_latch_q[1]);
endmodule : pio_ports

// file: tb/pio_board.sv
// board model: resolves pins from design drive, resistors and forcing
`timescale 1ns/10ps
module pio_board (
	// design drive
	input  wire logic [7:0]  p0_o_i,
	input  wire logic [7:0]  p0_oe_i,
	input  wire logic [1:0]  p1_o_i,
	input  wire logic [1:0]  p1_oe_i,
	input  wire logic [7:0]  p2_o_i,
	input  wire logic [7:0]  p2_oe_i,
	// board forcing, port two in the top byte
	input  wire logic [23:0] frc_v_i,
	input  wire logic [23:0] frc_en_i,
	// resolved levels
	output logic [7:0]       p0_pin_o,
	output logic [7:0]       p1_pin_o,
	output logic [7:0]       p2_pin_o
);
	logic [23:0] oe;
	logic [23:0] o;
	logic [23:0] lvl;
	// upper port one bits have no design drive at all
	assign oe = {p2_oe_i, 6'h00, p1_oe_i, p0_oe_i};
	assign o  = {p2_o_i, 6'h00, p1_o_i, p0_o_i};
	// released pins rise through resistors, forcing sets the frc_v_i level
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			lvl[i] = oe[i] ? o[i] : (frc_en_i[i] ? frc_v_i[i] : 1'b1);
		end
	end
	assign {p2_pin_o, p1_pin_o, p0_pin_o} = lvl;
endmodule : pio_board

// file: tb/pio_ports_tb_top.sv
// self-checking bench for the parallel io ports
`timescale 1ns/10ps
module pio_ports_tb_top;
	import pio_pkg::*;
	logic            clk_i = 1'b0;
	logic            rstn_i = 1'b0;
	pio_core_t       core_i = '0;
	logic            rmw_i = 1'b0;
	logic            ext_acc_i = 1'b0;
	logic [7:0]      ext_p0_i = '0;
	logic [7:0]      ext_p2_i = '0;
	logic            pwm_channel_zero_out_en_i = 1'b0;
	logic            pwm_channel_one_out_en_i = 1'b0;
	logic            pwm_channel_zero_out_i = 1'b0;
	logic            pwm_channel_one_out_i = 1'b0;
	logic            timer_two_count_input_o;
	logic            timer_two_capture_trigger_o;
	logic [5:0]      ain_sel_o;
	logic [7:0]      rdata_o, p0_pin_i, p1_pin_i, p2_pin_i;
	logic [7:0]      p0_pin_o, p0_pin_oe_o, p2_pin_o, p2_pin_oe_o;
	logic [1:0]      p1_pin_o, p1_pin_oe_o;
	pio_pull_t [1:0] p1_pull_o;
	pio_pull_t [7:0] p2_pull_o;
	logic [23:0]     frc_v = '0;
	logic [23:0]     frc_en = '0;
	logic [31:0]     lfsr = 32'h0001_75b0;
	int              err_count = 0, check_count = 0, cyc = 0, scnt = 0;
	int              lat [3];

	pio_ports i_dut (.clk_i, .rstn_i, .core_i, .rmw_i, .rdata_o, .ext_acc_i,
		.ext_p0_i, .ext_p2_i, .pwm_channel_zero_out_en_i, .pwm_channel_zero_out_i, .pwm_channel_one_out_en_i,
		.pwm_channel_one_out_i, .timer_two_count_input_o,
		.timer_two_capture_trigger_o, .ain_sel_o, .p0_pin_i, .p0_pin_o,
		.p0_pin_oe_o, .p1_pin_i, .p1_pin_o, .p1_pin_oe_o, .p1_pull_o,
		.p2_pin_i, .p2_pin_o, .p2_pin_oe_o, .p2_pull_o);
	pio_board i_board (.p0_o_i(p0_pin_o), .p0_oe_i(p0_pin_oe_o),
		.p1_o_i(p1_pin_o), .p1_oe_i(p1_pin_oe_o), .p2_o_i(p2_pin_o),
		.p2_oe_i(p2_pin_oe_o), .frc_v_i(frc_v), .frc_en_i(frc_en),
		.p0_pin_o(p0_pin_i), .p1_pin_o(p1_pin_i), .p2_pin_o(p2_pin_i));

	// 250 MHz core clock
	always #2 clk_i = ~clk_i;
	// hang guard, well above the roughly 450 cycles the run needs
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 6000) begin
			err_count++;
			results();
		end
	end
	// strong pull-up length meter on port two bit zero
	always @(negedge clk_i) begin
		if (p2_pull_o[0].strong_up === 1'b1) scnt++;
	end

	function automatic logic [7:0] rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return lfsr[7:0];
	endfunction : rnd
	// expected pin level: latch zero drives low, board forces low
	function automatic logic [7:0] pexp(int s);
		logic [7:0] lo;
		lo = frc_en[8*s +: 8];
		if (s == 1) return {~lo[7:2], 2'(lat[1]) & ~lo[1:0]};
		return 8'(lat[s]) & ~lo;
	endfunction : pexp
	task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic results();
		if (err_count == 0 && check_count > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : results
	// write strobe for one cycle, then one idle cycle
	task automatic wr(int s, logic [7:0] d);
		core_i.sel = pio_sel_t'(s);
		core_i.wdata = d;
		core_i.wr = 1'b1;
		@(negedge clk_i);
		core_i.wr = 1'b0;
		@(negedge clk_i);
		lat[s] = d;
	endtask : wr
	// mode 0 latch, 1 pin, 2 read-modify-write with pin strobe too
	task automatic rd(int s, int m, output logic [7:0] q);
		core_i.sel = pio_sel_t'(s);
		core_i.rd_latch = (m == 0);
		core_i.rd_pin = (m != 0);
		rmw_i = (m == 2);
		@(negedge clk_i);
		q = rdata_o;
		core_i.rd_latch = 1'b0;
		core_i.rd_pin = 1'b0;
		rmw_i = 1'b0;
		@(negedge clk_i);
	endtask : rd
	task automatic cmp_pins();
		chk("p0oe", p0_pin_oe_o, ~8'(lat[0]));
		chk("p0o", p0_pin_o & p0_pin_oe_o, 8'h00);
		chk("p2oe", p2_pin_oe_o, ~8'(lat[2]));
		chk("p2o", p2_pin_o & p2_pin_oe_o, 8'h00);
		chk("p1oe", {6'h00, p1_pin_oe_o}, {6'h00, ~2'(lat[1])});
		chk("ain", {2'h0, ain_sel_o}, 8'(lat[1] >> 2));
	endtask : cmp_pins

	initial begin
		logic [7:0] q, d;
		repeat (5) @(negedge clk_i);
		rstn_i = 1'b1;
		foreach (lat[i]) lat[i] = 255;
		@(negedge clk_i);
		// reset state of latches, drives and pull-ups
		for (int s = 0; s < 3; s++) begin
			rd(s, 0, q);
			chk("rst", q, 8'(lat[s]));
		end
		cmp_pins();
		chk("keep", {7'h0, p2_pull_o[3].keeper_up}, 8'h01);
		// random writes; forcing only pulls low, never against a drive
		for (int n = 0; n < 30; n++) begin
			frc_en = {rnd(), rnd(), rnd()};
			d = rnd();
			wr(n % 3, d);
			repeat (5) @(negedge clk_i);
			rd(n % 3, 1, q);
			chk("pin", q, pexp(n % 3));
			rd(n % 3, (n % 2) * 2, q);
			chk("latch", q, 8'(lat[n % 3]));
			cmp_pins();
		end
		frc_en = '0;
		// external cycle takes port zero and two; port zero write refused
		d = rnd();
		ext_p0_i = d;
		ext_p2_i = ~d;
		ext_acc_i = 1'b1;
		@(negedge clk_i);
		chk("xp0", p0_pin_o, d);
		chk("xp0oe", p0_pin_oe_o, 8'hff);
		chk("xp2", p2_pin_o, ~d);
		chk("xp2oe", p2_pin_oe_o, 8'hff);
		wr(0, 8'h00);
		ext_acc_i = 1'b0;
		lat[0] = 255;
		rd(0, 0, q);
		chk("xl0", q, 8'hff);
		rd(2, 0, q);
		chk("xl2", q, 8'(lat[2]));
		// pwm overrides a zero latch on both low pins
		wr(1, 8'hfc);
		pwm_channel_zero_out_en_i = 1'b1;
		pwm_channel_one_out_en_i = 1'b1;
		for (int v = 0; v < 4; v++) begin
			{pwm_channel_one_out_i, pwm_channel_zero_out_i} = 2'(v);
			@(negedge clk_i);
			chk("pwm", {4'h0, p1_pin_oe_o, p1_pin_o}, 8'(12 + v));
			repeat (4) @(negedge clk_i);
			chk("tmr0", {6'h0, timer_two_capture_trigger_o,
				timer_two_count_input_o}, 8'h00);
		end
		chk("p1pull", {p1_pull_o[1], p1_pull_o[0]}, 8'h00);
		pwm_channel_zero_out_en_i = 1'b0;
		pwm_channel_one_out_en_i = 1'b0;
		@(negedge clk_i);
		chk("p1low", {p1_pull_o[1], p1_pull_o[0]}, 8'h11);
		// timer inputs follow pins only while latch bits are one
		for (int v = 0; v < 8; v++) begin
			wr(1, {6'h3f, v[2] ? 2'b11 : 2'b00});
			frc_en[9:8] = 2'b11;
			frc_v[9:8] = 2'(v);
			repeat (6) @(negedge clk_i);
			chk("tmr", {6'h0, timer_two_capture_trigger_o,
				timer_two_count_input_o}, v[2] ? 8'(v & 3) : 8'h00);
		end
		frc_en = '0;
		// strong pull-up burst after a zero to one latch change
		wr(2, 8'h00);
		scnt = 0;
		wr(2, 8'hff);
		repeat (6) @(negedge clk_i);
		chk("strong", 8'(scnt), 8'(PIO_STRONG_PER));
		chk("keep1", {7'h0, p2_pull_o[0].keeper_up}, 8'h01);
		frc_en[16] = 1'b1;
		repeat (8) @(negedge clk_i);
		chk("keep0", {6'h0, p2_pull_o[0].keeper_up, p2_pull_o[0].weak_up},
			8'h01);
		frc_en = '0;
		results();
	end
endmodule : pio_ports_tb_top
